/* logic/plsdr_top.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - D15 mirrors the host interrupt output
// - D14 shows count interrupt flag
// - D13 shows attention interrupt flag
// - D12 shows end-of-DMA interrupt flag
// - D11 shows live attention input level
// - D10..D8 show status inputs C, B, A
// - D7 reads back command initialize bit
// - D6..D4 read back function outputs 3..1
// - D3 and D2 always read zero
// - D1 reads back inert block-mode bit
// - D0 set while DMA holds ready off
// - DMA or idle software write drives data
// - Count in bytes, bit zero always zero
// - Host bursts even, at most 64 bytes
// - Separate 128-byte FIFOs per direction
// - Two-wire word handshake, programmable skew
// - Programmed and DMA transfers, selectable direction
// - Data true, control polarity programmable
// - Host side 32-bit target, 33 MHz
// - 4 KB window, 256 bytes of registers
// - Attention aborts DMA unless keep bit set
module plsdr_top
    import plsdr_pkg::*;
(
    // Clock, reset, enable
    input  wire logic             SYS_CLK,
    input  wire logic             SYS_RST,
    input  wire logic             SYS_CE,
    // Register port
    input  wire logic [11:0]      REG_ADDR,
    input  wire logic             REG_RD,
    input  wire logic             REG_WR,
    input  wire logic [31:0]      REG_WDATA,
    output logic [31:0]           REG_RDATA,
    output logic                  REG_ACK,
    // Command and configuration bits, interrupt control
    input  wire plsdr_ctrl_type   CMD,
    input  wire plsdr_pol_type    CFG_POL,
    input  wire logic [1:0]       CFG_SKEW,
    input  wire logic             DMA_START,
    input  wire logic [31:0]      DMA_BYTES,
    input  wire logic [2:0]       IRQ_CLEAR,
    output logic                  HOST_IRQ,
    // Host bus master data path
    output logic                  MST_REQ,
    output logic                  MST_TO_MEM,
    output logic [6:0]            MST_BYTES,
    input  wire logic             MST_GNT,
    input  wire logic             MST_RVALID,
    input  wire logic [15:0]      MST_RDATA,
    output logic                  MST_RREADY,
    output logic                  MST_WVALID,
    output logic [15:0]           MST_WDATA,
    input  wire logic             MST_WREADY,
    // Parallel link
    input  wire logic [15:0]      LINK_DIN,
    output logic [15:0]           LINK_DOUT,
    input  wire logic             LINK_CYC_REQ,
    output logic                  LINK_BUSY,
    output logic                  LINK_READY,
    input  wire logic             LINK_ATTENTION_INPUT,
    input  wire logic [2:0]       LINK_STATUS
);
    localparam int FDEPTH = FIFO_BYTES / WORD_BYTES;
    localparam int LW     = $clog2(FDEPTH) + 1;

    plsdr_state_type st_q;
    logic [31:0] link_cnt_q;
    logic [31:0] host_rem_q;
    logic [5:0]  beats_q;
    logic [4:0]  skew_q;
    logic [15:0] data_q;
    logic        loaded_q;
    logic        to_mem_q;
    logic        cyc_prev_q;
    logic        attention_input_prev_q;
    logic        cnt_flag_q;
    logic        attention_input_flag_q;
    logic        dma_flag_q;
    logic        active;
    logic        cyc_lvl;
    logic        cyc_edge;
    logic        attention_input_lvl;
    logic        attention_input_rise;
    logic        abort;
    logic        start;
    logic        pop_out;
    logic        word_done;
    logic        cnt_hit;
    logic        dma_end;
    logic        sw_data_wr;
    logic [15:0] status_w;
    logic [6:0]  burst_w;
    logic        burst_ok;
    logic        in_wr_ready;
    logic        in_rd_valid;
    logic [15:0] in_rd_data;
    logic        out_wr_ready;
    logic        out_rd_valid;
    logic [15:0] out_rd_data;
    logic [LW-1:0] in_lvl;
    logic [LW-1:0] out_lvl;

    // ----------------------------------------------------------------
    // Link handshake decode
    // ----------------------------------------------------------------
    assign active    = (st_q != L_IDLE);
    assign cyc_lvl   = LINK_CYC_REQ ^ CFG_POL.cyc_req_low;
    assign attention_input_lvl  = LINK_ATTENTION_INPUT ^ CFG_POL.attention_low;
    assign cyc_edge  = cyc_lvl && !cyc_prev_q;
    assign attention_input_rise = attention_input_lvl && !attention_input_prev_q;
    assign abort     = attention_input_rise && active && !CMD.keep_transfer_on_attention;
    assign start     = (st_q == L_IDLE) && DMA_START;
    assign cnt_hit   = (st_q == L_WAIT) && (link_cnt_q == '0) && !abort;
    assign pop_out   = (st_q == L_WAIT) && !to_mem_q && !loaded_q && out_rd_valid
                       && (link_cnt_q != '0) && !abort;
    assign word_done = (st_q == L_BUSY) && (skew_q == '0) && (!to_mem_q || in_wr_ready)
                       && !abort;
    assign dma_end   = (st_q == L_END) && !abort
                       && (!to_mem_q || ((host_rem_q == '0) && (beats_q == '0)));
    assign sw_data_wr = REG_WR && (REG_ADDR == DATA_OFS) && !active;

    // Outputs follow the programmed polarity; data stays true
    assign LINK_BUSY  = (st_q == L_BUSY) ^ CFG_POL.busy_low;
    assign LINK_READY = !active ^ CFG_POL.ready_low;
    assign LINK_DOUT  = data_q;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            cyc_prev_q  <= 1'b0;
            attention_input_prev_q <= 1'b0;
        end else if (SYS_CE) begin
            cyc_prev_q  <= cyc_lvl;
            attention_input_prev_q <= attention_input_lvl;
        end
    end

    // ----------------------------------------------------------------
    // Link word sequencer
    // ----------------------------------------------------------------
    // Each word: request edge, busy held for the skew time, then release
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            st_q       <= L_IDLE;
            link_cnt_q <= COUNT_RST;
            skew_q     <= '0;
            loaded_q   <= 1'b0;
            to_mem_q   <= 1'b0;
        end else if (SYS_CE) begin
            if (abort) begin
                st_q     <= L_IDLE;
                loaded_q <= 1'b0;
            end else begin
                unique case (st_q)
                    L_IDLE: begin
                        if (start) begin
                            st_q       <= L_WAIT;
                            link_cnt_q <= {DMA_BYTES[31:1], 1'b0};
                            to_mem_q   <= CMD.dma_to_mem;
                            loaded_q   <= 1'b0;
                        end
                    end
                    L_WAIT: begin
                        if (link_cnt_q == '0) begin
                            st_q <= L_END;
                        end else if (pop_out) begin
                            loaded_q <= 1'b1;
                        end else if (cyc_edge && (to_mem_q || loaded_q)) begin
                            st_q   <= L_BUSY;
                            skew_q <= 5'((32'(CFG_SKEW) + 1) * SKEW_STEP_CYC - 1);
                        end
                    end
                    L_BUSY: begin
                        if (skew_q != '0) begin
                            skew_q <= skew_q - 1'b1;
                        end else if (word_done) begin
                            st_q       <= L_WAIT;
                            loaded_q   <= 1'b0;
                            link_cnt_q <= link_cnt_q - 32'(WORD_BYTES);
                        end
                    end
                    L_END: begin
                        if (dma_end) begin
                            st_q <= L_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Data word: DMA owns it while active, software only when idle
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            data_q <= DATA_RST;
        end else if (SYS_CE) begin
            if (pop_out) begin
                data_q <= out_rd_data;
            end else if (word_done && to_mem_q) begin
                data_q <= LINK_DIN;
            end else if (sw_data_wr) begin
                data_q <= REG_WDATA[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Direction buffers
    // ----------------------------------------------------------------
    plsdr_fifo #(.WIDTH(16), .DEPTH(FDEPTH)) u_in_fifo (
        .clk      (SYS_CLK),
        .rst      (SYS_RST),
        .ce       (SYS_CE),
        .flush    (abort || start),
        .wr_valid (word_done && to_mem_q),
        .wr_ready (in_wr_ready),
        .wr_data  (LINK_DIN),
        .rd_valid (in_rd_valid),
        .rd_ready (MST_WREADY && MST_WVALID),
        .rd_data  (in_rd_data),
        .level    (in_lvl)
    );

    plsdr_fifo #(.WIDTH(16), .DEPTH(FDEPTH)) u_out_fifo (
        .clk      (SYS_CLK),
        .rst      (SYS_RST),
        .ce       (SYS_CE),
        .flush    (abort || start),
        .wr_valid (MST_RVALID && MST_RREADY),
        .wr_ready (out_wr_ready),
        .wr_data  (MST_RDATA),
        .rd_valid (out_rd_valid),
        .rd_ready (pop_out),
        .rd_data  (out_rd_data),
        .level    (out_lvl)
    );

    // ----------------------------------------------------------------
    // Host bus master bursts
    // ----------------------------------------------------------------
    // One burst outstanding at a time keeps FIFO space accounting exact
    assign burst_w = to_mem_q
        ? plsdr_burst(host_rem_q, 32'(in_lvl) * WORD_BYTES)
        : plsdr_burst(host_rem_q, (32'(FDEPTH) - 32'(out_lvl)) * WORD_BYTES);
    assign burst_ok = active && !MST_REQ && (beats_q == '0) && (burst_w != '0)
        && ((burst_w == 7'(BURST_MAX)) || (32'(burst_w) == host_rem_q));
    assign MST_TO_MEM = to_mem_q;
    assign MST_WVALID = active && to_mem_q && (beats_q != '0) && in_rd_valid;
    assign MST_WDATA  = in_rd_data;
    assign MST_RREADY = active && !to_mem_q && (beats_q != '0) && out_wr_ready;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            MST_REQ    <= 1'b0;
            MST_BYTES  <= '0;
            host_rem_q <= COUNT_RST;
            beats_q    <= '0;
        end else if (SYS_CE) begin
            if (abort) begin
                MST_REQ    <= 1'b0;
                host_rem_q <= COUNT_RST;
                beats_q    <= '0;
            end else if (start) begin
                host_rem_q <= {DMA_BYTES[31:1], 1'b0};
            end else if (MST_REQ) begin
                if (MST_GNT) begin
                    MST_REQ    <= 1'b0;
                    beats_q    <= MST_BYTES[6:1];
                    host_rem_q <= host_rem_q - 32'(MST_BYTES);
                end
            end else if (burst_ok) begin
                MST_REQ   <= 1'b1;
                MST_BYTES <= burst_w;
            end else if ((MST_WVALID && MST_WREADY) || (MST_RVALID && MST_RREADY)) begin
                beats_q <= beats_q - 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt flags; a set in the clear cycle wins
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            cnt_flag_q  <= 1'b0;
            attention_input_flag_q <= 1'b0;
            dma_flag_q  <= 1'b0;
        end else if (SYS_CE) begin
            cnt_flag_q  <= cnt_hit || (cnt_flag_q && !IRQ_CLEAR[0]);
            attention_input_flag_q <= attention_input_rise || (attention_input_flag_q && !IRQ_CLEAR[1]);
            dma_flag_q  <= dma_end || (dma_flag_q && !IRQ_CLEAR[2]);
        end
    end

    assign HOST_IRQ = cnt_flag_q || attention_input_flag_q || dma_flag_q;

    // ----------------------------------------------------------------
    // Register reads; only REG_RDATA and REG_ACK change
    // ----------------------------------------------------------------
    assign status_w = {HOST_IRQ, cnt_flag_q, attention_input_flag_q, dma_flag_q,
                       attention_input_lvl, LINK_STATUS,
                       CMD.init_bit, CMD.function_out_3,
                       CMD.function_out_2, CMD.function_out_1,
                       2'b00, CMD.legacy_block_mode_bit, active};

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= '0;
            REG_ACK   <= 1'b0;
        end else if (SYS_CE) begin
            REG_ACK   <= REG_RD || REG_WR;
            REG_RDATA <= '0;
            if (REG_RD && (REG_ADDR < REG_SPAN)) begin
                unique case (REG_ADDR)
                    STATUS_OFS: REG_RDATA <= {16'h0000, status_w};
                    DATA_OFS:   REG_RDATA <= {16'h0000, data_q};
                    COUNT_OFS:  REG_RDATA <= link_cnt_q;
                    default:    REG_RDATA <= '0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    irq_bit_a: assert property (SYS_CE && REG_RD && REG_ADDR == STATUS_OFS
        |=> REG_RDATA[IRQ_POS] == $past(HOST_IRQ))
        else $error("status D15 differs from interrupt output");
    cnt_flag_a: assert property (SYS_CE && cnt_hit |=> cnt_flag_q && HOST_IRQ)
        else $error("count flag not raised at zero count");
    attention_input_flag_a: assert property (SYS_CE && attention_input_rise |=> attention_input_flag_q)
        else $error("attention flag not raised");
    dma_flag_a: assert property (SYS_CE && dma_end |=> dma_flag_q && st_q == L_IDLE)
        else $error("end of DMA not flagged");
    stat_pins_a: assert property (SYS_CE && REG_RD && REG_ADDR == STATUS_OFS
        |=> REG_RDATA[10:STAT_LO_POS] == $past(LINK_STATUS)
            && REG_RDATA[3:RSVD_LO_POS] == 2'b00
            && REG_RDATA[ACTIVE_POS] == $past(active))
        else $error("status pins, reserved or active bit wrong");
    ready_act_a: assert property (SYS_CE && start |=> LINK_READY == CFG_POL.ready_low)
        else $error("ready level does not match transfer state");
    sw_data_a: assert property (SYS_CE && sw_data_wr
        |=> LINK_DOUT == $past(REG_WDATA[15:0]))
        else $error("idle data write not on output bus");
    count_lsb_a: assert property (!link_cnt_q[0] && !host_rem_q[0])
        else $error("byte count odd");
    burst_size_a: assert property (MST_REQ |-> MST_BYTES != '0
        && MST_BYTES <= 7'(BURST_MAX) && !MST_BYTES[0])
        else $error("illegal host burst size");
    busy_hold_a: assert property (disable iff (SYS_RST || abort)
        $rose(st_q == L_BUSY) |-> (st_q == L_BUSY)[*5])
        else $error("busy released before skew time");
    attention_input_abort_a: assert property (SYS_CE && abort |=> st_q == L_IDLE && !MST_REQ)
        else $error("attention did not abort transfer");
    read_quiet_a: assert property (SYS_CE && REG_RD && !REG_WR && st_q == L_IDLE
        && !DMA_START && !attention_input_rise && IRQ_CLEAR == 3'b000
        |=> $stable(st_q) && $stable(data_q) && $stable(HOST_IRQ))
        else $error("register read changed state");

    dma_done_c: cover property (st_q == L_END ##1 st_q == L_IDLE);
    abort_c: cover property (SYS_CE && abort);
    burst_c: cover property (MST_REQ && MST_GNT && MST_BYTES == 7'(BURST_MAX));
    sw_write_c: cover property (SYS_CE && sw_data_wr);

endmodule
`default_nettype wire

/* logic/plsdr_pkg.sv */
`default_nettype none
package plsdr_pkg;

    // ----------------------------------------------------------------
    // Register map (byte offsets inside the 4 KB memory window)
    // ----------------------------------------------------------------
    localparam logic [11:0] STATUS_OFS    = 12'h0C8;
    localparam logic [11:0] DATA_OFS      = 12'h0CA;
    localparam logic [11:0] COUNT_OFS     = 12'h0CC;
    localparam logic [11:0] REG_SPAN      = 12'h100;

    // ----------------------------------------------------------------
    // Status word field positions
    // ----------------------------------------------------------------
    localparam int IRQ_POS       = 15;
    localparam int CNT_IRQ_POS   = 14;
    localparam int ATTENTION_INPUT_IRQ_POS  = 13;
    localparam int DMA_IRQ_POS   = 12;
    localparam int ATTENTION_INPUT_POS      = 11;
    localparam int STAT_LO_POS   = 8;
    localparam int INIT_POS      = 7;
    localparam int FUNC_LO_POS   = 4;
    localparam int RSVD_LO_POS   = 2;
    localparam int LEGACY_BLOCK_MODE_BIT_POS      = 1;
    localparam int ACTIVE_POS    = 0;

    // ----------------------------------------------------------------
    // Reset values and sizes
    // ----------------------------------------------------------------
    localparam logic [15:0] DATA_RST      = 16'h0000;
    localparam logic [31:0] COUNT_RST     = 32'h0000_0000;
    localparam int          WORD_BYTES    = 2;
    localparam int          BURST_MAX     = 64;
    localparam int          FIFO_BYTES    = 128;
    localparam int          HOST_MAX_MHZ  = 33;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SKEW_STEP_NS  = 40;
    localparam int SKEW_STEP_CYC = (SKEW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic init_bit;
        logic function_out_3;
        logic function_out_2;
        logic function_out_1;
        logic legacy_block_mode_bit;
        logic keep_transfer_on_attention;
        logic dma_to_mem;
    } plsdr_ctrl_type;

    // A set bit means the control line is asserted low
    typedef struct packed {
        logic cyc_req_low;
        logic busy_low;
        logic ready_low;
        logic attention_low;
    } plsdr_pol_type;

    localparam plsdr_pol_type POL_RST = 4'h0;

    typedef enum logic [1:0] {
        L_IDLE = 2'b00,
        L_WAIT = 2'b01,
        L_BUSY = 2'b11,
        L_END  = 2'b10
    } plsdr_state_type;

    // Largest even burst allowed by what remains and what the FIFO holds (to memory) or has free (from memory)
    function automatic logic [6:0] plsdr_burst(input logic [31:0] rem,
                                               input logic [31:0] avail);
        logic [31:0] m;
        m = (rem < avail) ? rem : avail;
        m = (m > 32'(BURST_MAX)) ? 32'(BURST_MAX) : m;
        return {m[6:1], 1'b0};
    endfunction

endpackage
`default_nettype wire

/* logic/plsdr_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module plsdr_fifo
    import plsdr_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = FIFO_BYTES / WORD_BYTES
) (
    // Clock, reset, enable
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    input  wire logic                       flush,
    // Fill side
    input  wire logic                       wr_valid,
    output logic                            wr_ready,
    input  wire logic [WIDTH-1:0]           wr_data,
    // Drain side
    output logic                            rd_valid,
    input  wire logic                       rd_ready,
    output logic [WIDTH-1:0]                rd_data,
    output logic [$clog2(DEPTH):0]          level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign wr_ready = (cnt_q != (AW+1)'(DEPTH));
    assign rd_valid = (cnt_q != '0);
    assign rd_data  = mem_q[rp_q];
    assign level    = cnt_q;
    assign push     = wr_valid && wr_ready;
    assign pop      = rd_valid && rd_ready;

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem_q[wp_q] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            if (flush) begin
                wp_q  <= '0;
                rp_q  <= '0;
                cnt_q <= '0;
            end else begin
                if (push) begin
                    wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
                end
                if (pop) begin
                    rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
                end
                cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
            end
        end
    end

endmodule
`default_nettype wire

/* verification/plsdr_link_model.sv */
`timescale 1ns/10ps
`default_nettype none
module plsdr_link_model (
    // Handshake seen from the card
    input  wire logic        clk,
    input  wire logic        busy,
    // Lines toward the card
    output logic [15:0] din,
    output logic        cyc_req,
    output logic        attention_input,
    output logic [2:0]  stat
);
    initial begin
        din = 16'h0000;
        cyc_req = 1'b0;
        attention_input = 1'b0;
        stat = 3'h0;
    end
    // No word held: keep the bus moving so a stale value cannot match
    always @(negedge clk) if (!busy) din <= ~din;
    task automatic set_lines(input logic a, input logic [2:0] s);
        @(negedge clk);
        attention_input = a;
        stat = s;
    endtask
    // One word toward the card; busy freezes din, so the value seen at busy is the one taken
    task automatic word(output logic [15:0] w);
        @(negedge clk);
        cyc_req = 1'b1;
        @(posedge busy);
        w = din;
        @(negedge busy);
        @(negedge clk);
        cyc_req = 1'b0;
    endtask
endmodule
`default_nettype wire

/* verification/parallel_link_status_data_regs_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module parallel_link_status_data_regs_bench;
    import plsdr_pkg::*;
    // ----------------------------------------
    // Stimulus, model state
    // ----------------------------------------
    logic clk = 0, rst = 1, rd = 0, wr = 0, ds = 0, ack, irq, busy, rdy, attention_input, cyc;
    logic [11:0] addr = 0;
    logic [31:0] wd = 0, rdat, nb = 0;
    logic [15:0] din, dout, dv;
    logic [2:0] clr = 0, stat;
    plsdr_ctrl_type cmd = '0;
    logic ce = 1;
    plsdr_pol_type pol = '0;
    int error_cnt = 0, checked = 0, cyc_n = 0, af = 0, act = 0, cf = 0, df = 0;
    always #4 clk = ~clk;
    plsdr_top dut (.SYS_CLK(clk), .SYS_RST(rst), .SYS_CE(ce), .REG_ADDR(addr), .REG_RD(rd),
        .REG_WR(wr), .REG_WDATA(wd), .REG_RDATA(rdat), .REG_ACK(ack), .CMD(cmd), .CFG_POL(pol),
        .CFG_SKEW(2'h0), .DMA_START(ds), .DMA_BYTES(nb), .IRQ_CLEAR(clr), .HOST_IRQ(irq),
        .MST_REQ(), .MST_TO_MEM(), .MST_BYTES(), .MST_GNT(1'b0), .MST_RVALID(1'b0),
        .MST_RDATA(16'h0000), .MST_RREADY(), .MST_WVALID(), .MST_WDATA(), .MST_WREADY(1'b1),
        .LINK_DIN(din), .LINK_DOUT(dout), .LINK_CYC_REQ(cyc), .LINK_BUSY(busy),
        .LINK_READY(rdy), .LINK_ATTENTION_INPUT(attention_input), .LINK_STATUS(stat));
    plsdr_link_model m (.clk(clk), .busy(busy), .din(din), .cyc_req(cyc), .attention_input(attention_input),
        .stat(stat));
    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_op(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        rd = !w;
        wr = w;
        @(negedge clk);
        rd = 0;
        wr = 0;
        chk({31'h0, ack}, 32'h1);
    endtask
    function automatic logic [31:0] st_exp();
        return {16'h0000, 1'(af | cf | df), 1'(cf), 1'(af), 1'(df), attention_input, stat[2], stat[1], stat[0],
            cmd.init_bit, cmd.function_out_3, cmd.function_out_2, cmd.function_out_1,
            2'b00, cmd.legacy_block_mode_bit, 1'(act)};
    endfunction
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n > 3000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(99));
        pol.ready_low = 1'($urandom);
        repeat (3) @(negedge clk);
        rst = 0;
        repeat (6) begin
            cmd = plsdr_ctrl_type'($urandom);
            m.set_lines(1'b0, 3'($urandom));
            reg_op(0, STATUS_OFS, 0);
            chk(rdat, st_exp());
        end
        dv = 16'($urandom);
        reg_op(1, DATA_OFS, {16'hFFFF, dv});
        reg_op(0, DATA_OFS, 0);
        chk(rdat, {16'h0000, dv});
        chk({16'h0000, dout}, {16'h0000, dv});
        reg_op(0, 12'h0D0, 0);
        chk(rdat, 32'h0000_0000);
        reg_op(0, 12'h1C8, 0);
        chk(rdat, 32'h0000_0000);
        // Zero-length DMA: count flag, then end flag, straight away
        cmd.dma_to_mem = 1'($urandom);
        nb = 32'($urandom_range(0, 1));
        @(negedge clk);
        ds = 1;
        @(negedge clk);
        ds = 0;
        repeat (2) @(negedge clk);
        cf = 1;
        df = 1;
        reg_op(0, STATUS_OFS, 0);
        chk(rdat, st_exp());
        clr = 3'b101;
        @(negedge clk);
        clr = 3'b000;
        cf = 0;
        df = 0;
        chk({31'h0, irq}, 32'h0);
        // Memory-to-link DMA that never gets the bus: it stays active until an attention with the keep bit clear aborts it
        cmd.dma_to_mem = 0;
        cmd.keep_transfer_on_attention = 1;
        nb = 32'($urandom_range(4, 999));
        @(negedge clk);
        ds = 1;
        @(negedge clk);
        ds = 0;
        act = 1;
        reg_op(0, COUNT_OFS, 0);
        chk(rdat, nb & 32'hFFFF_FFFE);
        chk({31'h0, rdy}, {31'h0, pol.ready_low});
        reg_op(1, DATA_OFS, {16'h0000, ~dv});
        reg_op(0, DATA_OFS, 0);
        chk(rdat, {16'h0000, dv});
        m.set_lines(1'b1, stat);
        af = 1;
        repeat (2) begin
            reg_op(0, STATUS_OFS, 0);
            chk(rdat, st_exp());
        end
        m.set_lines(1'b0, stat);
        cmd.keep_transfer_on_attention = 0;
        m.set_lines(1'b1, stat);
        act = 0;
        repeat (2) @(negedge clk);
        reg_op(0, STATUS_OFS, 0);
        chk(rdat, st_exp());
        chk({31'h0, rdy}, {31'h0, !pol.ready_low});
        m.set_lines(1'b0, stat);
        // A clear seen with the enable low must be ignored
        ce = 0;
        clr = 3'b010;
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        ce = 1;
        @(negedge clk);
        clr = 3'b000;
        af = 0;
        reg_op(0, STATUS_OFS, 0);
        chk(rdat, st_exp());
        chk({31'h0, irq}, 32'h0);
        // Link-to-memory word: the word taken lands in the data register
        cmd.dma_to_mem = 1;
        nb = 32'($urandom_range(2, 3));
        @(negedge clk);
        ds = 1;
        @(negedge clk);
        ds = 0;
        act = 1;
        m.word(dv);
        repeat (2) @(negedge clk);
        cf = 1;
        reg_op(0, DATA_OFS, 0);
        chk(rdat, {16'h0000, dv});
        chk({16'h0000, dout}, {16'h0000, dv});
        reg_op(0, COUNT_OFS, 0);
        chk(rdat, 32'h0000_0000);
        reg_op(0, STATUS_OFS, 0);
        chk(rdat, st_exp());
        give_verdict();
    end
endmodule
`default_nettype wire
